// File: hdl/gpds_consts.svh
// Constants for the group power-down sequencer
`ifndef GPDS_CONSTS_SVH
`define GPDS_CONSTS_SVH

`define GPDS_NREG 8
`define GPDS_NGRP 4
`define GPDS_CLK_MHZ 100
// Times in microseconds
`define GPDS_GAP0_US 120
`define GPDS_GAP1_US 250
`define GPDS_GAP2_US 500
`define GPDS_GAP3_US 1000
`define GPDS_LEAD1_US 10
`define GPDS_LEAD2_US 100
`define GPDS_LEAD3_US 500
`define GPDS_HOLD1_US 1500
`define GPDS_HOLD2_US 5000
`define GPDS_HOLD3_US 10000
`define GPDS_US2CYC(us) ((us) * `GPDS_CLK_MHZ)
`define GPDS_CNT_W 20
`define GPDS_SEL_ZERO 2'b00
`define GPDS_SEL_ONE 2'b01
`define GPDS_SEL_TWO 2'b10
`define GPDS_SEL_THREE 2'b11
`define GPDS_GROUP_MODE 1'b1

`endif

// File: hdl/gpds_pkg.sv
// Types for the group power-down sequencer
package gpds_pkg;
    typedef enum logic [5:0] {
        GPDS_IDLE = 6'b00_0001,
        GPDS_PICK = 6'b00_0010,
        GPDS_LEAD = 6'b00_0100,
        GPDS_GAP = 6'b00_1000,
        GPDS_HOLD = 6'b01_0000,
        GPDS_DONE = 6'b10_0000
    } gpds_state_t;
endpackage : gpds_pkg

// File: hdl/gpds_sequencer.sv
// Group power-down sequencer with per-regulator fault handling
`timescale 1ns/1ns
`default_nettype none
`include "gpds_consts.svh"

module gpds_sequencer
    import gpds_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RSTN,
    // Sequence control
    input wire logic SHUTDOWN_STYLE_SEL,
    input wire logic POWER_DOWN_REQ,
    input wire logic POWER_ON_REQUEST_PIN,
    input wire logic POWER_GOOD_PIN_AS_GPO,
    input wire logic OFF_MODE,
    input wire logic POWER_UP_DONE,
    input wire logic MONITOR_ACTIVE,
    // Functional settings from the host
    input wire logic [15:0] POWER_DOWN_GROUP_SEL,
    input wire logic [1:0] POWER_GOOD_PIN_GROUP_SEL,
    input wire logic [1:0] HOST_RESET_GROUP_SEL,
    input wire logic [7:0] GROUP_GAP_DELAY_SEL,
    input wire logic [1:0] HOST_RESET_LEAD_DELAY_SEL,
    input wire logic SETTINGS_WE,
    // Mirror values used on reload, then the restart hold-off select and its OTP gate
    input wire logic [15:0] MIRROR_GROUP_SEL,
    input wire logic [1:0] MIRROR_POWER_GOOD_PIN_GROUP_SEL,
    input wire logic [1:0] MIRROR_RESET_GROUP_SEL,
    input wire logic [7:0] MIRROR_GAP_SEL,
    input wire logic [1:0] MIRROR_LEAD_SEL,
    input wire logic [1:0] RESTART_HOLDOFF_SEL,
    input wire logic OTP_PROGRAMMED,
    // Faults and fault settings
    input wire logic [7:0] CURRENT_LIMIT_FAULT,
    input wire logic [7:0] OVERVOLTAGE_FAULT,
    input wire logic [7:0] UNDERVOLTAGE_FAULT,
    input wire logic [7:0] CURRENT_LIMIT_KEEP_ON,
    input wire logic [7:0] OVERVOLTAGE_KEEP_ON,
    input wire logic [7:0] UNDERVOLTAGE_KEEP_ON,
    input wire logic [23:0] FAULT_MASK,
    input wire logic FAULT_CFG_WE,
    // Outputs
    output logic [7:0] REG_ENABLE,
    output logic GENERAL_OUTPUT,
    output logic HOST_RESET_OUT,
    output logic INTERRUPT_OUT_N,
    output logic POWER_UP_ALLOWED,
    output logic SEQ_BUSY,
    output logic [2:0] ACTIVE_GROUP
);
    gpds_state_t state, next_state;
    logic [1:0] grp, next_grp;   // 0 = Group 4 ... 3 = Group 1
    logic [`GPDS_CNT_W-1:0] cnt, next_cnt;
    logic [7:0] seq_off, next_seq_off;
    logic gpo_off, next_gpo_off;
    logic rst_on, next_rst_on;
    logic [15:0] grp_sel, next_grp_sel;
    logic [1:0] pg_sel, next_pg_sel;
    logic [1:0] hr_sel, next_hr_sel;
    logic [7:0] gap_sel, next_gap_sel;
    logic [1:0] lead_sel, next_lead_sel;
    logic [1:0] hold_sel, next_hold_sel;
    logic [7:0] kill, next_kill;
    logic [7:0] current_limit_fault_keep, ov_keep, uv_keep;
    logic [7:0] next_current_limit_fault_keep, next_ov_keep, next_uv_keep;
    logic [23:0] mask, next_mask;
    logic irq, next_irq;
    logic [3:0] populated;
    logic [7:0] in_grp;
    logic [1:0] last_grp;
    logic any_pop;
    logic [`GPDS_CNT_W-1:0] gap_cyc, lead_cyc, hold_cyc;

    // Group select code equals hierarchy index from Group 4
    genvar gi;
    generate
        for (gi = 0; gi < `GPDS_NREG; gi = gi + 1) begin : g_reg
            assign in_grp[gi] = (grp_sel[2*gi +: 2] == grp);
        end
    endgenerate

    // Group membership, with the host reset pin and the power-good pin used as a GPO counted as members
    always_comb begin
        populated = '0;
        for (int r = 0; r < `GPDS_NREG; r++) begin
            populated[grp_sel[2*r +: 2]] = 1'b1;
        end
        if (POWER_GOOD_PIN_AS_GPO) begin
            populated[pg_sel] = 1'b1;
        end
        // Host reset counts even with no rails in its group
        populated[hr_sel] = 1'b1;
        any_pop = |populated;
        last_grp = `GPDS_SEL_ZERO;
        for (int g = 0; g < `GPDS_NGRP; g++) begin
            if (populated[g]) begin
                last_grp = 2'(g);
            end
        end
    end

    // Delay lookups
    always_comb begin
        case (gap_sel[2*grp +: 2])
            `GPDS_SEL_ZERO: gap_cyc = `GPDS_CNT_W'(`GPDS_US2CYC(`GPDS_GAP0_US));
            `GPDS_SEL_ONE: gap_cyc = `GPDS_CNT_W'(`GPDS_US2CYC(`GPDS_GAP1_US));
            `GPDS_SEL_TWO: gap_cyc = `GPDS_CNT_W'(`GPDS_US2CYC(`GPDS_GAP2_US));
            default: gap_cyc = `GPDS_CNT_W'(`GPDS_US2CYC(`GPDS_GAP3_US));
        endcase
        case (lead_sel)
            `GPDS_SEL_ZERO: lead_cyc = '0;
            `GPDS_SEL_ONE: lead_cyc = `GPDS_CNT_W'(`GPDS_US2CYC(`GPDS_LEAD1_US));
            `GPDS_SEL_TWO: lead_cyc = `GPDS_CNT_W'(`GPDS_US2CYC(`GPDS_LEAD2_US));
            default: lead_cyc = `GPDS_CNT_W'(`GPDS_US2CYC(`GPDS_LEAD3_US));
        endcase
        case (hold_sel)
            `GPDS_SEL_ZERO: hold_cyc = '0;
            `GPDS_SEL_ONE: hold_cyc = `GPDS_CNT_W'(`GPDS_US2CYC(`GPDS_HOLD1_US));
            `GPDS_SEL_TWO: hold_cyc = `GPDS_CNT_W'(`GPDS_US2CYC(`GPDS_HOLD2_US));
            default: hold_cyc = `GPDS_CNT_W'(`GPDS_US2CYC(`GPDS_HOLD3_US));
        endcase
    end

    // Sequencer
    always_comb begin
        next_state = state;
        next_grp = grp;
        next_cnt = cnt;
        next_seq_off = seq_off;
        next_gpo_off = gpo_off;
        next_rst_on = rst_on;
        case (state)
            GPDS_IDLE: begin
                if (POWER_DOWN_REQ && SHUTDOWN_STYLE_SEL == `GPDS_GROUP_MODE) begin
                    next_grp = `GPDS_SEL_ZERO;
                    next_state = any_pop ? GPDS_PICK : GPDS_HOLD;
                    // Preloaded for a set with no members at all
                    next_cnt = hold_cyc;
                end
            end
            GPDS_PICK: begin
                if (!populated[grp]) begin
                    next_grp = grp + 2'd1;
                end else if (hr_sel == grp && !rst_on && lead_cyc != '0) begin
                    next_rst_on = 1'b1;
                    next_cnt = lead_cyc;
                    next_state = GPDS_LEAD;
                end else begin
                    // Lead path returns here with host reset already high
                    next_seq_off = seq_off | in_grp;
                    if (hr_sel == grp) begin
                        next_rst_on = 1'b1;
                    end
                    if (POWER_GOOD_PIN_AS_GPO && pg_sel == grp) begin
                        next_gpo_off = 1'b1;
                    end
                    if (grp == last_grp) begin
                        next_cnt = hold_cyc;
                        next_state = GPDS_HOLD;
                    end else begin
                        next_cnt = gap_cyc;
                        next_state = GPDS_GAP;
                    end
                end
            end
            GPDS_LEAD: begin
                // Counter reaches one on the last cycle of the wait
                next_cnt = cnt - `GPDS_CNT_W'(1);
                if (cnt <= `GPDS_CNT_W'(1)) begin
                    next_state = GPDS_PICK;
                end
            end
            GPDS_GAP: begin
                next_cnt = cnt - `GPDS_CNT_W'(1);
                if (cnt <= `GPDS_CNT_W'(1)) begin
                    next_grp = grp + 2'd1;
                    next_state = GPDS_PICK;
                end
            end
            GPDS_HOLD: begin
                // Zero hold-off still spends one cycle here
                next_cnt = (cnt == '0) ? cnt : cnt - `GPDS_CNT_W'(1);
                if (cnt <= `GPDS_CNT_W'(1)) begin
                    next_state = GPDS_DONE;
                end
            end
            GPDS_DONE: begin
                // Only off mode rearms; power-on stays masked until then
                if (OFF_MODE) begin
                    next_seq_off = '0;
                    next_gpo_off = 1'b0;
                    next_rst_on = 1'b0;
                    next_state = GPDS_IDLE;
                end
            end
            default: next_state = GPDS_IDLE;
        endcase
    end

    // Settings: host writes, reload from mirrors on off mode
    always_comb begin
        next_grp_sel = grp_sel;
        next_pg_sel = pg_sel;
        next_hr_sel = hr_sel;
        next_gap_sel = gap_sel;
        next_lead_sel = lead_sel;
        next_hold_sel = OTP_PROGRAMMED ? RESTART_HOLDOFF_SEL : `GPDS_SEL_ZERO;
        // Off mode wins over a host write in the same cycle
        if (OFF_MODE) begin
            next_grp_sel = MIRROR_GROUP_SEL;
            next_pg_sel = MIRROR_POWER_GOOD_PIN_GROUP_SEL;
            next_hr_sel = MIRROR_RESET_GROUP_SEL;
            next_gap_sel = MIRROR_GAP_SEL;
            next_lead_sel = MIRROR_LEAD_SEL;
        end else if (SETTINGS_WE) begin
            next_grp_sel = POWER_DOWN_GROUP_SEL;
            next_pg_sel = POWER_GOOD_PIN_GROUP_SEL;
            next_hr_sel = HOST_RESET_GROUP_SEL;
            next_gap_sel = GROUP_GAP_DELAY_SEL;
            next_lead_sel = HOST_RESET_LEAD_DELAY_SEL;
        end
    end

    // Fault handling
    always_comb begin
        next_current_limit_fault_keep = current_limit_fault_keep;
        next_ov_keep = ov_keep;
        next_uv_keep = uv_keep;
        next_mask = mask;
        next_kill = kill;
        next_irq = 1'b0;
        if (POWER_UP_DONE || OFF_MODE) begin
            next_current_limit_fault_keep = '0;
            next_ov_keep = '0;
            next_uv_keep = '0;
            next_mask = '0;
            next_kill = '0;
        end else if (FAULT_CFG_WE) begin
            next_current_limit_fault_keep = CURRENT_LIMIT_KEEP_ON;
            next_ov_keep = OVERVOLTAGE_KEEP_ON;
            next_uv_keep = UNDERVOLTAGE_KEEP_ON;
            next_mask = FAULT_MASK;
        end
        // A fault in the clearing cycle still sets its latch
        if (MONITOR_ACTIVE) begin
            next_kill = next_kill | (CURRENT_LIMIT_FAULT & ~current_limit_fault_keep)
                | (OVERVOLTAGE_FAULT & ~ov_keep)
                | (UNDERVOLTAGE_FAULT & ~uv_keep);
            next_irq = |({UNDERVOLTAGE_FAULT, OVERVOLTAGE_FAULT, CURRENT_LIMIT_FAULT}
                & ~mask);
        end
    end

    // Sequencer registers
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= GPDS_IDLE;
            grp <= `GPDS_SEL_ZERO;
            cnt <= '0;
            seq_off <= '0;
            gpo_off <= 1'b0;
            rst_on <= 1'b0;
        end else begin
            state <= next_state;
            grp <= next_grp;
            cnt <= next_cnt;
            seq_off <= next_seq_off;
            gpo_off <= next_gpo_off;
            rst_on <= next_rst_on;
        end
    end

    // Settings; power-good select resets to Group 1
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            grp_sel <= '0;
            pg_sel <= `GPDS_SEL_THREE;
            hr_sel <= `GPDS_SEL_ZERO;
            gap_sel <= '0;
            lead_sel <= `GPDS_SEL_ZERO;
            hold_sel <= `GPDS_SEL_ZERO;
        end else begin
            grp_sel <= next_grp_sel;
            pg_sel <= next_pg_sel;
            hr_sel <= next_hr_sel;
            gap_sel <= next_gap_sel;
            lead_sel <= next_lead_sel;
            hold_sel <= next_hold_sel;
        end
    end

    // Fault latches hold a rail off until power-up ends or off mode
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            kill <= '0;
            current_limit_fault_keep <= '0;
            ov_keep <= '0;
            uv_keep <= '0;
            mask <= '0;
            irq <= 1'b0;
        end else begin
            kill <= next_kill;
            current_limit_fault_keep <= next_current_limit_fault_keep;
            ov_keep <= next_ov_keep;
            uv_keep <= next_uv_keep;
            mask <= next_mask;
            irq <= next_irq;
        end
    end

    // Outputs; power-on is masked for the whole sequence
    // Enable low while sequenced off or killed by a fault
    assign REG_ENABLE = ~(seq_off | kill);
    assign GENERAL_OUTPUT = POWER_GOOD_PIN_AS_GPO & ~gpo_off;
    assign HOST_RESET_OUT = rst_on;
    assign INTERRUPT_OUT_N = ~irq;
    assign POWER_UP_ALLOWED = POWER_ON_REQUEST_PIN & (state == GPDS_IDLE);
    assign SEQ_BUSY = (state != GPDS_IDLE) && (state != GPDS_DONE);
    assign ACTIVE_GROUP = 3'(`GPDS_NGRP) - {1'b0, grp};
endmodule : gpds_sequencer
`default_nettype wire

// File: test/gpds_properties.sv
// Checker for the group power-down sequencer ports
`timescale 1ns/1ns
`default_nettype none
module gpds_properties (
    // Clock, reset and controls
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic SHUTDOWN_STYLE_SEL,
    input wire logic MONITOR_ACTIVE,
    input wire logic [1:0] HOST_RESET_LEAD_DELAY_SEL,
    input wire logic [7:0] CURRENT_LIMIT_FAULT,
    input wire logic [7:0] CURRENT_LIMIT_KEEP_ON,
    input wire logic [23:0] FAULT_MASK,
    // Outputs
    input wire logic [7:0] REG_ENABLE,
    input wire logic HOST_RESET_OUT,
    input wire logic INTERRUPT_OUT_N,
    input wire logic POWER_UP_ALLOWED,
    input wire logic SEQ_BUSY,
    input wire logic [2:0] ACTIVE_GROUP
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    // Cycles since host reset rose with the shortest lead, until its group drops
    logic [10:0] lead_cnt;
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            lead_cnt <= 11'h000;
        end else if ($rose(HOST_RESET_OUT) && HOST_RESET_LEAD_DELAY_SEL == 2'h1) begin
            lead_cnt <= 11'h001;
        end else if (lead_cnt != 11'h000 && REG_ENABLE == $past(REG_ENABLE)) begin
            lead_cnt <= lead_cnt + 11'h001;
        end else begin
            lead_cnt <= 11'h000;
        end
    end
    sequence s_lead_one;
        $rose(HOST_RESET_OUT) && HOST_RESET_LEAD_DELAY_SEL == 2'h1;
    endsequence
    sequence s_regs_held;
        $stable(REG_ENABLE) [*8];
    endsequence
    property p_style_gate;
        !SHUTDOWN_STYLE_SEL && !SEQ_BUSY |=> !SEQ_BUSY;
    endproperty
    a_style_gate: assert property (p_style_gate) else $error("start in slot style");
    property p_off_in_seq;
        !MONITOR_ACTIVE && |($past(REG_ENABLE) & ~REG_ENABLE) |-> $past(SEQ_BUSY);
    endproperty
    a_off_in_seq: assert property (p_off_in_seq) else $error("rail off outside");
    property p_order;
        SEQ_BUSY && $past(SEQ_BUSY) && ACTIVE_GROUP != $past(ACTIVE_GROUP)
            |-> ACTIVE_GROUP == $past(ACTIVE_GROUP) - 3'h1;
    endproperty
    a_order: assert property (p_order) else $error("group order wrong");
    property p_lead_hold;
        s_lead_one |=> s_regs_held;
    endproperty
    a_lead_hold: assert property (p_lead_hold) else $error("lead too short");
    property p_lead_drop;
        lead_cnt < 11'h3EB;
    endproperty
    a_lead_drop: assert property (p_lead_drop) else $error("lead too long");
    property p_lead_zero;
        $rose(HOST_RESET_OUT) && HOST_RESET_LEAD_DELAY_SEL == 2'h0
            |-> REG_ENABLE != $past(REG_ENABLE);
    endproperty
    a_lead_zero: assert property (p_lead_zero) else $error("group late");
    property p_masked_on;
        SEQ_BUSY |-> !POWER_UP_ALLOWED;
    endproperty
    a_masked_on: assert property (p_masked_on) else $error("power-on not masked");
    property p_fault_int;
        MONITOR_ACTIVE && |(CURRENT_LIMIT_FAULT & ~FAULT_MASK[7:0]) |=> !INTERRUPT_OUT_N;
    endproperty
    a_fault_int: assert property (p_fault_int) else $error("no interrupt");
    property p_current_limit_fault_kill;
        MONITOR_ACTIVE && |(CURRENT_LIMIT_FAULT & ~CURRENT_LIMIT_KEEP_ON)
            |=> (REG_ENABLE & $past(CURRENT_LIMIT_FAULT & ~CURRENT_LIMIT_KEEP_ON)) == 8'h00;
    endproperty
    a_current_limit_fault_kill: assert property (p_current_limit_fault_kill) else $error("rail kept on");
endmodule : gpds_properties
bind gpds_sequencer gpds_properties gpds_properties_i (.*);
`default_nettype wire

// File: test/gpds_rails.sv
// Rail and host model facing the sequencer
`timescale 1ns/1ns
`default_nettype none
module gpds_rails (
    // Sequencer side
    input wire logic [7:0] REG_ENABLE,
    input wire logic POWER_GOOD_PIN_AS_GPO,
    input wire logic [1:0] gpo_group,
    // Faults commanded by the bench
    input wire logic [7:0] current_limit_fault_hit,
    input wire logic [7:0] ov_hit,
    input wire logic [7:0] uv_hit,
    // Rail status back
    output logic [7:0] CURRENT_LIMIT_FAULT,
    output logic [7:0] OVERVOLTAGE_FAULT,
    output logic [7:0] UNDERVOLTAGE_FAULT,
    output logic [1:0] POWER_GOOD_PIN_GROUP_SEL
);
    // A rail that is off reports nothing
    assign CURRENT_LIMIT_FAULT = current_limit_fault_hit & REG_ENABLE;
    assign OVERVOLTAGE_FAULT = ov_hit & REG_ENABLE;
    assign UNDERVOLTAGE_FAULT = uv_hit & REG_ENABLE;
    // Parks the power-good pin in Group 1 unless it is used as a GPO
    assign POWER_GOOD_PIN_GROUP_SEL = POWER_GOOD_PIN_AS_GPO ? gpo_group : 2'h3;
endmodule : gpds_rails
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the group power-down sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic SYS_CLK, RSTN, SHUTDOWN_STYLE_SEL, POWER_DOWN_REQ, POWER_ON_REQUEST_PIN;
    logic POWER_GOOD_PIN_AS_GPO, OFF_MODE, POWER_UP_DONE, MONITOR_ACTIVE, SETTINGS_WE;
    logic OTP_PROGRAMMED, FAULT_CFG_WE, GENERAL_OUTPUT, HOST_RESET_OUT;
    logic INTERRUPT_OUT_N, POWER_UP_ALLOWED, SEQ_BUSY;
    logic [15:0] POWER_DOWN_GROUP_SEL, MIRROR_GROUP_SEL;
    logic [1:0] HOST_RESET_GROUP_SEL, HOST_RESET_LEAD_DELAY_SEL, MIRROR_POWER_GOOD_PIN_GROUP_SEL;
    logic [1:0] MIRROR_RESET_GROUP_SEL, MIRROR_LEAD_SEL, RESTART_HOLDOFF_SEL;
    logic [1:0] gpo_group, POWER_GOOD_PIN_GROUP_SEL;
    logic [7:0] GROUP_GAP_DELAY_SEL, MIRROR_GAP_SEL, CURRENT_LIMIT_KEEP_ON;
    logic [7:0] OVERVOLTAGE_KEEP_ON, UNDERVOLTAGE_KEEP_ON, CURRENT_LIMIT_FAULT;
    logic [7:0] OVERVOLTAGE_FAULT, UNDERVOLTAGE_FAULT, current_limit_fault_hit, ov_hit, uv_hit, REG_ENABLE;
    logic [23:0] FAULT_MASK;
    logic [2:0] ACTIVE_GROUP;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;
    gpds_sequencer gpds_sequencer_i (.*);
    gpds_rails gpds_rails_i (.*);
    task automatic tick(input int k = 1);
        repeat (k) @(negedge SYS_CLK);
    endtask : tick
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8
    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        n_tests++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_rng
    task automatic conclude();
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic leave_off();
        OFF_MODE = 1'b1;
        tick(2);
        OFF_MODE = 1'b0;
        tick();
        chk8("restored", 8'hFF, REG_ENABLE);
        chk8("power-on", 8'h01, {7'h0, POWER_UP_ALLOWED});
    endtask : leave_off
    task automatic t_groups();
        POWER_DOWN_GROUP_SEL = 16'hFF00;
        HOST_RESET_GROUP_SEL = 2'h3;
        gpo_group = 2'h1;
        POWER_GOOD_PIN_AS_GPO = 1'b1;
        SETTINGS_WE = 1'b1;
        tick();
        SETTINGS_WE = 1'b0;
        POWER_ON_REQUEST_PIN = 1'b1;
        POWER_DOWN_REQ = 1'b1;
        tick();
        POWER_DOWN_REQ = 1'b0;
        tick();
        chk8("group4 off", 8'hF0, REG_ENABLE);
        chk8("gpo early", 8'h01, {7'h0, GENERAL_OUTPUT});
        chk8("masked", 8'h00, {7'h0, POWER_UP_ALLOWED});
        chk8("active group", 8'h04, {5'h0, ACTIVE_GROUP});
        for (n = 0; n < 13000 && GENERAL_OUTPUT !== 1'b0; n++) tick();
        chk_rng("gap to group3", 12000, 12003, n);
        for (n = 0; n < 13000 && HOST_RESET_OUT !== 1'b1; n++) tick();
        chk_rng("gap to group1", 12000, 12004, n);
        chk8("group1 off", 8'h00, REG_ENABLE);
        for (n = 0; n < 6 && SEQ_BUSY !== 1'b0; n++) tick();
        chk_rng("no hold-off", 0, 3, n);
        chk8("done masked", 8'h00, {7'h0, POWER_UP_ALLOWED});
        {MIRROR_LEAD_SEL, HOST_RESET_LEAD_DELAY_SEL} = 4'h5;
        POWER_GOOD_PIN_AS_GPO = 1'b0;
        leave_off();
    endtask : t_groups
    task automatic t_lead();
        POWER_DOWN_REQ = 1'b1;
        tick();
        POWER_DOWN_REQ = 1'b0;
        for (n = 0; n < 8 && HOST_RESET_OUT !== 1'b1; n++) tick();
        for (n = 0; n < 1100 && REG_ENABLE !== 8'h00; n++) tick();
        chk_rng("lead delay", 1000, 1002, n);
        for (n = 0; n < 40000 && SEQ_BUSY !== 1'b0; n++) tick();
        chk8("finished", 8'h00, {7'h0, SEQ_BUSY});
        leave_off();
    endtask : t_lead
    task automatic t_style();
        SHUTDOWN_STYLE_SEL = 1'b0;
        POWER_DOWN_REQ = 1'b1;
        tick(20);
        POWER_DOWN_REQ = 1'b0;
        chk8("slot style", 8'hFF, REG_ENABLE & {7'h7F, ~SEQ_BUSY});
        SHUTDOWN_STYLE_SEL = 1'b1;
    endtask : t_style
    task automatic hit(input logic [23:0] f, input logic [7:0] er, input logic in_n);
        {uv_hit, ov_hit, current_limit_fault_hit} = f;
        tick();
        chk8("rails", er, REG_ENABLE);
        chk8("irq", {7'h0, in_n}, {7'h0, INTERRUPT_OUT_N});
        {uv_hit, ov_hit, current_limit_fault_hit} = 24'h00_0000;
        POWER_UP_DONE = 1'b1;
        tick();
        POWER_UP_DONE = 1'b0;
        tick();
    endtask : hit
    task automatic t_faults();
        {OVERVOLTAGE_KEEP_ON, FAULT_MASK, MONITOR_ACTIVE, FAULT_CFG_WE} = 34'h0_0800_0803;
        tick();
        FAULT_CFG_WE = 1'b0;
        {uv_hit, ov_hit, current_limit_fault_hit} = 24'h00_0200;
        tick();
        chk8("ov kept", 8'hFF, REG_ENABLE);
        chk8("ov masked", 8'h01, {7'h0, INTERRUPT_OUT_N});
        hit(24'h04_0000, 8'hFB, 1'b0);
        hit(24'h00_0200, 8'hFD, 1'b0);
        MONITOR_ACTIVE = 1'b0;
        current_limit_fault_hit = 8'h01;
        tick(2);
        chk8("idle monitor", 8'hFF, REG_ENABLE);
        MONITOR_ACTIVE = 1'b1;
        hit(24'h00_0001, 8'hFE, 1'b0);
    endtask : t_faults
    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc == 80000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        {RSTN, POWER_DOWN_REQ, POWER_ON_REQUEST_PIN, POWER_GOOD_PIN_AS_GPO, OFF_MODE, POWER_UP_DONE,
            MONITOR_ACTIVE, SETTINGS_WE, OTP_PROGRAMMED, FAULT_CFG_WE, POWER_DOWN_GROUP_SEL,
            MIRROR_GROUP_SEL, HOST_RESET_GROUP_SEL, HOST_RESET_LEAD_DELAY_SEL,
            MIRROR_RESET_GROUP_SEL, MIRROR_LEAD_SEL, gpo_group, GROUP_GAP_DELAY_SEL,
            MIRROR_GAP_SEL, CURRENT_LIMIT_KEEP_ON, OVERVOLTAGE_KEEP_ON, UNDERVOLTAGE_KEEP_ON,
            current_limit_fault_hit, ov_hit, uv_hit, FAULT_MASK} = '0;
        SHUTDOWN_STYLE_SEL = 1'b1;
        MIRROR_POWER_GOOD_PIN_GROUP_SEL = 2'h3;
        // Unprogrammed memory must override this select
        RESTART_HOLDOFF_SEL = 2'h3;
        tick(6);
        RSTN = 1'b1;
        tick();
        chk8("reset", 8'hFF, REG_ENABLE);
        chk8("reset pins", 8'h02, {5'h0, HOST_RESET_OUT, INTERRUPT_OUT_N, SEQ_BUSY});
        t_groups();
        t_lead();
        t_style();
        t_faults();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
